// ---- hw/jlss_cfg.svh ----
// constants of the lane sync status register bank
// assumes one register clock and a byte-wide register port
//
// Contract
// - per lane, symbol lock bit at its lane position, 1 locked, 0 lost
// - frame lock register, one bit per lane 7..0, 1 locked, 0 lost
// - checksum register, one bit per lane, 1 checksum matches, 0 mismatch
// - all lane status shows the link chosen by the link page field
// - eight lanes, lane 7 in the msb, lane 0 in the lsb
`ifndef JLSS_CFG_SVH
`define JLSS_CFG_SVH

`define JLSS_ADDR_LINK_PAGE 12'h300
`define JLSS_ADDR_SYMBOL_LOCK 12'h470
`define JLSS_ADDR_FRAME_LOCK 12'h471
`define JLSS_ADDR_CHECKSUM_OK 12'h472
`define JLSS_ADDR_IRQ_STATUS 12'h4F0
`define JLSS_ADDR_IRQ_MASK 12'h4F1

`define JLSS_PAGE_LSB 0
`define JLSS_PAGE_WIDTH 3
`define JLSS_RESET_VALUE 8'h00

`define JLSS_EVT_SYMBOL_LOST 0
`define JLSS_EVT_FRAME_LOST 1
`define JLSS_EVT_CHECKSUM_BAD 2
`define JLSS_EVT_COUNT 3

`endif

// ---- hw/jlss_pkg.sv ----
// types shared by the lane sync status register bank
// assumes nothing beyond the constants header
package jlss_pkg;

  typedef struct packed
  {
    logic [7:0] symbol_lock;
    logic [7:0] frame_lock;
    logic [7:0] checksum_ok;
  } jlss_lane_s;

  typedef struct packed
  {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } jlss_bus_s;

endpackage

// ---- hw/jlss_sync2.sv ----
// two-flop synchroniser for a vector of levels
// assumes the levels change slowly against clk_in
`timescale 1ns/1ps
module jlss_sync2
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      meta_ff <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // jlss_sync2

// ---- hw/jlss_lane_sync_status_regs.sv ----
// paged read-only lane sync status registers with loss interrupt
// assumes lane status levels come from the receive link logic, asynchronous
`timescale 1ns/1ps
`include "jlss_cfg.svh"
module jlss_lane_sync_status_regs
#(
  parameter int NUM_LINKS = 2
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire jlss_pkg::jlss_bus_s bus_in,
  input wire jlss_pkg::jlss_lane_s [NUM_LINKS-1:0] link_status_in,
  output logic [7:0] rdata_out,
  output logic irq_out
);
  import jlss_pkg::*;

  localparam int SW = $bits(jlss_lane_s);

  jlss_lane_s [NUM_LINKS-1:0] status_sync;
  jlss_lane_s [NUM_LINKS-1:0] status_prev_ff;
  logic [`JLSS_PAGE_WIDTH-1:0] page_ff;
  logic [`JLSS_EVT_COUNT-1:0] irq_status_ff;
  logic [`JLSS_EVT_COUNT-1:0] irq_mask_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;

  // status is never stored writable: it is the synchronised live level
  jlss_sync2 #(.WIDTH(NUM_LINKS * SW)) u_sync
  (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in(link_status_in),
    .sync_out(status_sync)
  );

  // page beyond the last link shows zeros rather than aliasing
  wire page_valid = 32'(page_ff) < NUM_LINKS;
  jlss_lane_s shown;
  assign shown = page_valid ? status_sync[page_ff] : '0;

  wire sel_page = bus_in.addr == `JLSS_ADDR_LINK_PAGE;
  wire sel_sym = bus_in.addr == `JLSS_ADDR_SYMBOL_LOCK;
  wire sel_frame = bus_in.addr == `JLSS_ADDR_FRAME_LOCK;
  wire sel_cks = bus_in.addr == `JLSS_ADDR_CHECKSUM_OK;
  wire sel_ista = bus_in.addr == `JLSS_ADDR_IRQ_STATUS;
  wire sel_imask = bus_in.addr == `JLSS_ADDR_IRQ_MASK;

  // loss events across every link, not only the shown page
  wire [NUM_LINKS-1:0] sym_lost;
  wire [NUM_LINKS-1:0] frame_lost;
  wire [NUM_LINKS-1:0] cks_lost;
  wire [`JLSS_EVT_COUNT-1:0] evt;

  for (genvar l = 0; l < NUM_LINKS; l++)
  begin : g_loss
    assign sym_lost[l] = |(status_prev_ff[l].symbol_lock & ~status_sync[l].symbol_lock);
    assign frame_lost[l] = |(status_prev_ff[l].frame_lock & ~status_sync[l].frame_lock);
    assign cks_lost[l] = |(status_prev_ff[l].checksum_ok & ~status_sync[l].checksum_ok);
  end

  assign evt[`JLSS_EVT_SYMBOL_LOST] = |sym_lost;
  assign evt[`JLSS_EVT_FRAME_LOST] = |frame_lost;
  assign evt[`JLSS_EVT_CHECKSUM_BAD] = |cks_lost;

  wire [`JLSS_EVT_COUNT-1:0] w1c = (bus_in.wr && sel_ista) ? bus_in.wdata[`JLSS_EVT_COUNT-1:0] : '0;
  // set wins over a clear in the same cycle
  wire [`JLSS_EVT_COUNT-1:0] nxt_irq_status = (irq_status_ff & ~w1c) | evt;
  wire nxt_irq = |(nxt_irq_status & irq_mask_ff);

  wire [7:0] nxt_rdata =
    sel_sym ? shown.symbol_lock :
    sel_frame ? shown.frame_lock :
    sel_cks ? shown.checksum_ok :
    sel_page ? 8'(page_ff) :
    sel_ista ? 8'(irq_status_ff) :
    sel_imask ? 8'(irq_mask_ff) : `JLSS_RESET_VALUE;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      status_prev_ff <= '0;
      page_ff <= '0;
      irq_status_ff <= '0;
      irq_mask_ff <= '0;
      rdata_ff <= `JLSS_RESET_VALUE;
      irq_ff <= 1'b0;
    end
    else
    begin
      status_prev_ff <= status_sync;
      irq_status_ff <= nxt_irq_status;
      irq_ff <= nxt_irq;
      // page and mask accept writes, irq status clears on write-one; lane status addresses ignore them
      if (bus_in.wr && sel_page)
        page_ff <= bus_in.wdata[`JLSS_PAGE_LSB +: `JLSS_PAGE_WIDTH];
      if (bus_in.wr && sel_imask)
        irq_mask_ff <= bus_in.wdata[`JLSS_EVT_COUNT-1:0];
      rdata_ff <= bus_in.rd ? nxt_rdata : `JLSS_RESET_VALUE;
    end
  end

  assign rdata_out = rdata_ff;
  assign irq_out = irq_ff;

  property p_symbol_read;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.rd && bus_in.addr == `JLSS_ADDR_SYMBOL_LOCK) |=> rdata_out == $past(shown.symbol_lock);
  endproperty
  a_symbol_read: assert property (p_symbol_read) else $error("symbol lock read mismatch");

  property p_frame_read;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.rd && bus_in.addr == `JLSS_ADDR_FRAME_LOCK) |=> rdata_out == $past(shown.frame_lock);
  endproperty
  a_frame_read: assert property (p_frame_read) else $error("frame lock read mismatch");

  property p_checksum_read;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.rd && bus_in.addr == `JLSS_ADDR_CHECKSUM_OK) |=> rdata_out == $past(shown.checksum_ok);
  endproperty
  a_checksum_read: assert property (p_checksum_read) else $error("checksum read mismatch");

  property p_page_select;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.rd && bus_in.addr == `JLSS_ADDR_FRAME_LOCK && page_ff == 1 && NUM_LINKS > 1)
      |=> rdata_out == $past(status_sync[1].frame_lock);
  endproperty
  a_page_select: assert property (p_page_select) else $error("page 1 not shown");

  property p_lane7_msb;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.rd && bus_in.addr == `JLSS_ADDR_SYMBOL_LOCK && page_ff == 0)
      |=> rdata_out[7] == $past(status_sync[0].symbol_lock[7]) && rdata_out[0] == $past(status_sync[0].symbol_lock[0]);
  endproperty
  a_lane7_msb: assert property (p_lane7_msb) else $error("lane bit order wrong");

  property p_read_only;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.wr && bus_in.addr inside {`JLSS_ADDR_SYMBOL_LOCK, `JLSS_ADDR_FRAME_LOCK, `JLSS_ADDR_CHECKSUM_OK})
      |=> $stable(page_ff) && $stable(irq_mask_ff);
  endproperty
  a_read_only: assert property (p_read_only) else $error("status write changed state");

  property p_reset_clear;
    @(posedge clk_in)
    !resetn_in |=> rdata_out == 8'h00 && irq_out == 1'b0 && status_prev_ff == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear");

  property p_page_write;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.wr && bus_in.addr == `JLSS_ADDR_LINK_PAGE)
      |=> page_ff == $past(bus_in.wdata[`JLSS_PAGE_LSB +: `JLSS_PAGE_WIDTH]);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write lost");

  property p_page_read;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.rd && bus_in.addr == `JLSS_ADDR_LINK_PAGE) |=> rdata_out == 8'($past(page_ff));
  endproperty
  a_page_read: assert property (p_page_read) else $error("page readback mismatch");

  property p_page_invalid;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.rd && bus_in.addr == `JLSS_ADDR_SYMBOL_LOCK && 32'(page_ff) >= NUM_LINKS)
      |=> rdata_out == `JLSS_RESET_VALUE;
  endproperty
  a_page_invalid: assert property (p_page_invalid) else $error("unused page not zero");

  property p_read_idle;
    @(posedge clk_in) disable iff (!resetn_in)
    !bus_in.rd |=> rdata_out == `JLSS_RESET_VALUE;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");

  property p_mask_write;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.wr && bus_in.addr == `JLSS_ADDR_IRQ_MASK)
      |=> irq_mask_ff == $past(bus_in.wdata[`JLSS_EVT_COUNT-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_mask_read;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.rd && bus_in.addr == `JLSS_ADDR_IRQ_MASK) |=> rdata_out == 8'($past(irq_mask_ff));
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask readback mismatch");

  property p_irq_read;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.rd && bus_in.addr == `JLSS_ADDR_IRQ_STATUS) |=> rdata_out == 8'($past(irq_status_ff));
  endproperty
  a_irq_read: assert property (p_irq_read) else $error("irq status readback mismatch");

  property p_frame_lost;
    @(posedge clk_in) disable iff (!resetn_in)
    ((status_prev_ff[0].frame_lock & ~status_sync[0].frame_lock) != 8'h00)
      |=> irq_status_ff[`JLSS_EVT_FRAME_LOST];
  endproperty
  a_frame_lost: assert property (p_frame_lost) else $error("frame loss not flagged");

  property p_set_wins;
    @(posedge clk_in) disable iff (!resetn_in)
    (evt != '0) |=> (irq_status_ff & $past(evt)) == $past(evt);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("loss event dropped");

  property p_w1c_clear;
    @(posedge clk_in) disable iff (!resetn_in)
    (bus_in.wr && bus_in.addr == `JLSS_ADDR_IRQ_STATUS)
      |=> (irq_status_ff & $past(bus_in.wdata[`JLSS_EVT_COUNT-1:0]) & ~$past(evt)) == '0;
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("irq status not cleared");

  property p_irq_level;
    @(posedge clk_in) disable iff (!resetn_in)
    $stable(irq_mask_ff) |-> irq_out == |(irq_status_ff & irq_mask_ff);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level mismatch");

  property p_irq_needs_status;
    @(posedge clk_in) disable iff (!resetn_in)
    irq_out |-> irq_status_ff != '0;
  endproperty
  a_irq_needs_status: assert property (p_irq_needs_status) else $error("irq without status");
endmodule // jlss_lane_sync_status_regs

// ---- bench/jlss_far_tx.sv ----
// far-end transmitter model: per-link lane status levels
// assumes the bench calls set_link just after a rising edge
`timescale 1ns/1ps
module jlss_far_tx
#(
  parameter int NUM_LINKS = 2
)
(
  output jlss_pkg::jlss_lane_s [NUM_LINKS-1:0] status_out
);
  import jlss_pkg::*;
  jlss_lane_s [NUM_LINKS-1:0] lvl_ff = '0;
  // lock is a held level, so no idle pattern applies
  assign status_out = lvl_ff;
  task set_link(input int idx, input jlss_lane_s val);
    lvl_ff[idx] <= val;
  endtask
endmodule // jlss_far_tx

// ---- bench/jlss_lane_sync_status_regs_tb.sv ----
// bench for the paged lane sync status registers
// assumes the far-end model drives the lane status levels
`timescale 1ns/1ps
`include "jlss_cfg.svh"
module jlss_lane_sync_status_regs_tb;
  import jlss_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  jlss_bus_s bus = '0;
  jlss_lane_s [1:0] lanes;
  logic [7:0] rdata;
  logic irq;
  int bad_count = 0;
  int checked = 0;
  always #20 clk_in = ~clk_in;
  jlss_far_tx #(.NUM_LINKS(2)) far (.status_out(lanes));
  jlss_lane_sync_status_regs #(.NUM_LINKS(2)) dut (.clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus),
    .link_status_in(lanes), .rdata_out(rdata), .irq_out(irq));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask
  // read data lives one cycle only, so sample mid-cycle
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_in);
    bus.rd <= 1'b0;
    @(negedge clk_in);
    check(rdata, exp);
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge clk_in);
    bad_count++;
    wrap_up();
  end
  initial
  begin
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(negedge clk_in);
    check({7'h00, irq}, 8'h00);
    rd(`JLSS_ADDR_SYMBOL_LOCK, 8'h00);
    rd(`JLSS_ADDR_FRAME_LOCK, 8'h00);
    rd(`JLSS_ADDR_CHECKSUM_OK, 8'h00);
    // no bit palindromes, so a mirrored lane order shows
    @(posedge clk_in);
    far.set_link(0, '{8'hA1, 8'h3D, 8'h83});
    far.set_link(1, '{8'h5B, 8'hC6, 8'h74});
    // two sync flops, plus margin
    repeat (4) @(posedge clk_in);
    rd(`JLSS_ADDR_SYMBOL_LOCK, 8'hA1);
    rd(`JLSS_ADDR_FRAME_LOCK, 8'h3D);
    rd(`JLSS_ADDR_CHECKSUM_OK, 8'h83);
    wr(`JLSS_ADDR_LINK_PAGE, 8'h01);
    rd(`JLSS_ADDR_LINK_PAGE, 8'h01);
    rd(`JLSS_ADDR_SYMBOL_LOCK, 8'h5B);
    rd(`JLSS_ADDR_FRAME_LOCK, 8'hC6);
    rd(`JLSS_ADDR_CHECKSUM_OK, 8'h74);
    wr(`JLSS_ADDR_FRAME_LOCK, 8'hFF);
    rd(`JLSS_ADDR_FRAME_LOCK, 8'hC6);
    wr(`JLSS_ADDR_LINK_PAGE, 8'h02);
    rd(`JLSS_ADDR_SYMBOL_LOCK, 8'h00);
    wr(`JLSS_ADDR_IRQ_MASK, 8'h01);
    rd(`JLSS_ADDR_IRQ_MASK, 8'h01);
    @(posedge clk_in);
    far.set_link(1, '{8'h5A, 8'hC6, 8'h74});
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    check({7'h00, irq}, 8'h01);
    rd(`JLSS_ADDR_IRQ_STATUS, 8'h01);
    wr(`JLSS_ADDR_IRQ_STATUS, 8'h01);
    @(negedge clk_in);
    check({7'h00, irq}, 8'h00);
    // frame and checksum loss together, only frame enabled
    wr(`JLSS_ADDR_IRQ_MASK, 8'h02);
    @(posedge clk_in);
    far.set_link(0, '{8'hA1, 8'h39, 8'h82});
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
    check({7'h00, irq}, 8'h01);
    rd(`JLSS_ADDR_IRQ_STATUS, 8'h06);
    wr(`JLSS_ADDR_IRQ_STATUS, 8'h02);
    @(negedge clk_in);
    check({7'h00, irq}, 8'h00);
    rd(`JLSS_ADDR_IRQ_STATUS, 8'h04);
    // mask change reaches the pin one edge late
    wr(`JLSS_ADDR_IRQ_MASK, 8'h04);
    repeat (2) @(negedge clk_in);
    check({7'h00, irq}, 8'h01);
    // mid-run reset must drop page, mask, status and the interrupt
    wr(`JLSS_ADDR_LINK_PAGE, 8'h01);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(negedge clk_in);
    check({7'h00, irq}, 8'h00);
    rd(`JLSS_ADDR_LINK_PAGE, 8'h00);
    rd(`JLSS_ADDR_IRQ_STATUS, 8'h00);
    rd(`JLSS_ADDR_IRQ_MASK, 8'h00);
    rd(`JLSS_ADDR_SYMBOL_LOCK, 8'hA1);
    wrap_up();
  end
endmodule // jlss_lane_sync_status_regs_tb
